/* rtl/ger_consts.svh */
// Offsets, field positions, reset values and bus codes of the event router
`ifndef GER_CONSTS_SVH
`define GER_CONSTS_SVH

`define GER_ADDR_W          12
`define GER_DATA_W          32
`define GER_NPORTS          3

`define GER_CTL_OFFSET      12'h0450
`define GER_STS_OFFSET      12'h0454

`define GER_POL_BIT         0
`define GER_P1_BIT          1
`define GER_P6_BIT          6
`define GER_P7_BIT          7

`define GER_CTL_RESET       32'h0000_0000
`define GER_STS_RESET       32'h0000_0000
`define GER_POL_RESET       1'h0
`define GER_EN_RESET        3'h0

`define GER_RESP_OKAY       2'h0
`define GER_RESP_SLVERR     2'h2

`endif

/* rtl/ger_pkg.sv */
// Types shared by the event router and its register slave
package ger_pkg;

    typedef struct packed {
        logic        polarity_r;
        logic [2:0]  reroute_en_r;
        logic [2:0]  event_active_r;
        logic        shared_event_out_r;
        logic        shared_event_oe_r;
        logic [2:0]  std_notify_r;
    } ger_main_t;

    typedef struct packed {
        logic        awready_r;
        logic        wready_r;
        logic        aw_full_r;
        logic        w_full_r;
        logic [11:0] awaddr_r;
        logic [31:0] wdata_r;
        logic [3:0]  wstrb_r;
        logic        bvalid_r;
        logic [1:0]  bresp_r;
        logic        arready_r;
        logic        rvalid_r;
        logic [31:0] rdata_r;
        logic [1:0]  rresp_r;
    } ger_axil_t;

endpackage

/* rtl/ger_axil_slave.sv */
// AXI4-Lite slave front end for the event router registers
`include "ger_consts.svh"

module ger_axil_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_fire,
    output logic [11:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);

    ger_pkg::ger_axil_t s_r;
    ger_pkg::ger_axil_t s_nxt;

    assign wr_fire = s_r.aw_full_r & s_r.w_full_r & ~s_r.bvalid_r;
    assign wr_addr = s_r.awaddr_r;
    assign wr_data = s_r.wdata_r;
    assign wr_strb = s_r.wstrb_r;

    always_comb begin
        s_nxt = s_r;
        if (awvalid && s_r.awready_r) begin
            s_nxt.aw_full_r = 1'b1;
            s_nxt.awaddr_r  = awaddr;
        end
        if (wvalid && s_r.wready_r) begin
            s_nxt.w_full_r = 1'b1;
            s_nxt.wdata_r  = wdata;
            s_nxt.wstrb_r  = wstrb;
        end
        if (wr_fire) begin
            s_nxt.aw_full_r = 1'b0;
            s_nxt.w_full_r  = 1'b0;
            s_nxt.bvalid_r  = 1'b1;
            s_nxt.bresp_r   = wr_err ? `GER_RESP_SLVERR : `GER_RESP_OKAY;
        end
        if (s_r.bvalid_r && bready) begin
            s_nxt.bvalid_r = 1'b0;
        end
        // Stall new writes until the response is gone
        s_nxt.awready_r = ~s_nxt.aw_full_r & ~s_nxt.bvalid_r;
        s_nxt.wready_r  = ~s_nxt.w_full_r & ~s_nxt.bvalid_r;
        if (arvalid && s_r.arready_r) begin
            s_nxt.arready_r = 1'b0;
            s_nxt.rvalid_r  = 1'b1;
            s_nxt.rdata_r   = rd_data;
            s_nxt.rresp_r   = rd_err ? `GER_RESP_SLVERR : `GER_RESP_OKAY;
        end
        if (s_r.rvalid_r && rready) begin
            s_nxt.rvalid_r  = 1'b0;
            s_nxt.arready_r = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r           <= '0;
            s_r.awready_r <= 1'b1;
            s_r.wready_r  <= 1'b1;
            s_r.arready_r <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.awready_r;
    assign wready  = s_r.wready_r;
    assign bvalid  = s_r.bvalid_r;
    assign bresp   = s_r.bresp_r;
    assign arready = s_r.arready_r;
    assign rvalid  = s_r.rvalid_r;
    assign rdata   = s_r.rdata_r;
    assign rresp   = s_r.rresp_r;

endmodule

/* rtl/ger_top.sv */
// General purpose event router: reroutes hot-plug notifications to GPIO 7
//
// How it works
// RULE1 - One polarity bit for all ports; clear drives active low, set high.
// RULE2 - Enable bits 1, 6, 7 suppress that port's INTx/MSI/PME, use pin.
// RULE3 - Shared event drives GPIO 7 only when its alternate function is on.
// RULE4 - Status bits 1, 6, 7 read one while that port signals on the pin.
// RULE5 - Status bit never sets while the port's enable bit is clear.
// RULE6 - Pin asserted while any enabled port has a pending rerouted event.
//
// Port index 0, 1, 2 on the vector ports stands for switch ports 1, 6, 7.
//
// Local design decision: the AXI4-Lite interface to the registers.
`include "ger_consts.svh"

module ger_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite register port
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Hot-plug controllers of ports 1, 6, 7 (core clock)
    input  wire logic [2:0]  hp_event_pending,
    // Standard INTx/MSI/PME requests passed on to the port logic
    output logic [2:0]       std_notify_req,
    // GPIO 7 function select from the GPIO block (core clock)
    input  wire logic        gpio7_alt_sel,
    output logic             gpio7_alt_o,
    output logic             gpio7_alt_oe
);

    localparam int PORT_BIT [3] = '{`GER_P1_BIT, `GER_P6_BIT, `GER_P7_BIT};

    ger_pkg::ger_main_t st_r;
    ger_pkg::ger_main_t st_nxt;

    logic        wr_fire;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [31:0] rd_data;
    logic        rd_err;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [2:0]  en_from_bus;
    logic [2:0]  active_nxt;
    logic [2:0]  std_nxt;
    logic        any_active;

    ger_axil_slave u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_fire (wr_fire),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Register images; reserved bits read zero
    always_comb begin
        ctl_word = `GER_CTL_RESET;
        sts_word = `GER_STS_RESET;
        ctl_word[`GER_POL_BIT] = st_r.polarity_r;
        for (int i = 0; i < `GER_NPORTS; i++) begin
            ctl_word[PORT_BIT[i]] = st_r.reroute_en_r[i];
            sts_word[PORT_BIT[i]] = st_r.event_active_r[i];
        end
    end

    // Read decode on the word address, low two bits ignored
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        case ({s_axi_araddr[11:2], 2'h0})
            `GER_CTL_OFFSET: rd_data = ctl_word;
            `GER_STS_OFFSET: rd_data = sts_word;
            default:         rd_err  = 1'b1;
        endcase
    end

    // Status register is read-only; writes to it are accepted and dropped
    always_comb begin
        case ({wr_addr[11:2], 2'h0})
            `GER_CTL_OFFSET: wr_err = 1'b0;
            `GER_STS_OFFSET: wr_err = 1'b0;
            default:         wr_err = 1'b1;
        endcase
    end

    // Per-port routing, enables as they stand after this cycle's write
    genvar g;
    generate
        for (g = 0; g < `GER_NPORTS; g++) begin : g_port
            assign en_from_bus[g] = wr_data[PORT_BIT[g]];
            // Gate status by the enable so it can never set when disabled
            assign active_nxt[g] = hp_event_pending[g] &
                                   st_nxt.reroute_en_r[g]; // RULE4 RULE5
            // Standard notification only for ports not rerouted
            assign std_nxt[g] = hp_event_pending[g] &
                                ~st_nxt.reroute_en_r[g]; // RULE2
        end
    endgenerate

    assign any_active = |active_nxt; // RULE6

    always_comb begin
        st_nxt = st_r;
        if (wr_fire && wr_strb[0] &&
            ({wr_addr[11:2], 2'h0} == `GER_CTL_OFFSET)) begin
            st_nxt.polarity_r   = wr_data[`GER_POL_BIT]; // RULE1
            st_nxt.reroute_en_r = en_from_bus; // RULE2
        end
    end

    // Second stage: the outputs follow the updated control image
    ger_pkg::ger_main_t st_fin;
    always_comb begin
        st_fin = st_nxt;
        st_fin.event_active_r = active_nxt;
        st_fin.std_notify_r   = std_nxt;
        // Inactive level is the inverse of the asserted level
        st_fin.shared_event_out_r = any_active ~^ st_nxt.polarity_r; // RULE1
        // Pin is left to the GPIO block unless routed to this function
        st_fin.shared_event_oe_r  = gpio7_alt_sel; // RULE3
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r                    <= '0;
            st_r.polarity_r         <= `GER_POL_RESET;
            st_r.reroute_en_r       <= `GER_EN_RESET;
            // Deasserted, active-low default
            st_r.shared_event_out_r <= ~`GER_POL_RESET;
        end else begin
            st_r <= st_fin;
        end
    end

    assign std_notify_req = st_r.std_notify_r;
    assign gpio7_alt_o    = st_r.shared_event_out_r;
    assign gpio7_alt_oe   = st_r.shared_event_oe_r; // RULE3

endmodule

/* dv/ger_checker.sv */
// Assertions on the event router top ports
module ger_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic [2:0]  hp_event_pending,
    input wire logic [2:0]  std_notify_req,
    input wire logic        gpio7_alt_sel,
    input wire logic        gpio7_alt_o,
    input wire logic        gpio7_alt_oe
);
    logic       bv_r, pol_r, pol_now, fire;
    logic [2:0] en_r, en_now;
    // Relies on the master holding address and data until the next write
    assign fire    = s_axi_bvalid && !bv_r && s_axi_wstrb[0]
                     && s_axi_awaddr[11:2] == 10'h114;
    assign pol_now = fire ? s_axi_wdata[0] : pol_r;
    assign en_now  = fire ? {s_axi_wdata[7:6], s_axi_wdata[1]} : en_r;
    always_ff @(posedge aclk) begin
        bv_r  <= aresetn && s_axi_bvalid;
        pol_r <= aresetn && pol_now;
        en_r  <= aresetn ? en_now : 3'h0;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_idle;
        $rose(aresetn) |-> gpio7_alt_o && !gpio7_alt_oe;
    endproperty
    property p_pin;
        $past(aresetn) |-> gpio7_alt_o ==
            ((|($past(hp_event_pending) & en_now)) ? pol_now : !pol_now);
    endproperty
    property p_notify;
        $past(aresetn) |->
            std_notify_req == ($past(hp_event_pending) & ~en_now);
    endproperty
    property p_oe;
        $past(aresetn) |-> gpio7_alt_oe == $past(gpio7_alt_sel);
    endproperty
    property p_rsv;
        s_axi_rvalid |-> s_axi_rdata[31:8] == '0 && s_axi_rdata[5:2] == '0;
    endproperty
    property p_sts;
        $rose(s_axi_rvalid) && s_axi_araddr[11:2] == 10'h115
            |-> ({s_axi_rdata[7:6], s_axi_rdata[1]} & ~en_now) == 3'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("pin not idle after reset");
    a_pin: assert property (p_pin)
        else $error("pin level wrong");
    a_notify: assert property (p_notify)
        else $error("standard notify wrong");
    a_oe: assert property (p_oe)
        else $error("pin enable wrong");
    a_rsv: assert property (p_rsv)
        else $error("reserved read bits set");
    a_sts: assert property (p_sts)
        else $error("status set while disabled");
    c_fire: cover property (fire);
    c_drv: cover property (gpio7_alt_oe && gpio7_alt_o == pol_now);
    c_sts: cover property ($rose(s_axi_rvalid) && s_axi_rdata != '0);
endmodule

/* dv/ger_evt_sink.sv */
// System event logic model watching the shared event pin
module ger_evt_sink (
    input  wire logic active_high,
    input  wire logic pin,
    input  wire logic pin_oe,
    output logic      seen
);
    // Undriven pin never counts as an event
    assign seen = pin_oe && (pin == active_high);
endmodule

/* dv/general_purpose_event_router_tb.sv */
// Self-checking bench for the event router
module general_purpose_event_router_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = '0, aresetn = '0, sel = '0, pol = '0;
    logic        awvalid = '0, wvalid = '0, bready = '0;
    logic        arvalid = '0, rready = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0]  wstrb = '0;
    logic [2:0]  pend = '0, en = '0, notify;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, pin, oe, seen;
    int          errors = 0, checks_done = 0, seed = 8;

    always #50 aclk = ~aclk;

    ger_top dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .hp_event_pending(pend),
        .std_notify_req(notify), .gpio7_alt_sel(sel),
        .gpio7_alt_o(pin), .gpio7_alt_oe(oe)
    );
    ger_evt_sink sink_u (
        .active_high(pol), .pin(pin), .pin_oe(oe), .seen(seen)
    );

    function automatic logic [31:0] sts(input logic [2:0] p, e);
        sts = {24'h0, p[2] & e[2], p[1] & e[1], 4'h0, p[0] & e[0], 1'h0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        r = bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask

    task automatic outs;
        repeat (2) @(posedge aclk);
        chk("notify", 32'(pend & ~en), 32'(notify));
        chk("pin", 32'((|(pend & en)) ? pol : !pol), 32'(pin));
        chk("oe", 32'(sel), 32'(oe));
        chk("seen", 32'(sel && |(pend & en)), 32'(seen));
        rd(12'h454);
        chk("status", sts(pend, en), d);
    endtask

    task automatic step(input logic [31:0] c, input logic [3:0] ps);
        wr(12'h450, c, 4'hf);
        chk("ctl_resp", 32'h0, 32'(r));
        en = {c[7:6], c[1]};
        pol = c[0];
        rd(12'h450);
        chk("ctl", c & 32'h0000_00c3, d);
        @(posedge aclk);
        pend <= ps[2:0];
        sel <= ps[3];
        outs;
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        outs;
        rd(12'h450);
        chk("ctl_reset", 32'h0, d);
        rd(12'h458);
        chk("rd_unmapped", 32'h2, {d[29:0], r});
        wr(12'h458, 32'hffff_ffff, 4'hf);
        chk("wr_unmapped", 32'h2, 32'(r));
        step(32'h0000_00c2, 4'hf);
        // Status is read-only and a write without lane 0 changes nothing
        wr(12'h454, 32'h0, 4'hf);
        wr(12'h450, 32'h0, 4'h0);
        outs;
        step(32'h0000_00c3, 4'hf);
        step(32'h0000_0041, 4'h6);
        step(32'h0000_0000, 4'hf);
        repeat (40) begin
            d = $random(seed);
            step(d, d[11:8]);
        end
        complete_run;
    end

    initial begin
        repeat (8000) @(posedge aclk);
        errors++;
        complete_run;
    end
endmodule

bind ger_top ger_checker chk_u (.*);
